//--- rtl/vpgd_pkg.sv
// What this block does
// - write mode 0: fill-enabled planes take their fill byte, others rotated host data
// - compare read returns 1 where all compare-enabled planes match the reference colour; disabled planes count as matching
// - host byte rotated, then combined with latch: pass, AND, OR, XOR
// - plane read returns byte of the indexed plane; index ignored in compare reads
// - path 00: rotated data through fill mechanism into the logic unit
// - path 01: latches written straight into the planes, logic unit bypassed
// - path 10: host bit n replicated across all eight pixels of plane n
// - path 11: fill bits expanded per plane; rotated data AND bit enables is the mask
// - read select 0 reads indexed plane unless chained or odd/even is set; 1 reads compare result
// - odd/even bit set: address bit A0 picks even or odd plane on reads
// - packed colour load bit selects 256-colour loading, else interleave bit rules
// - graphics bit 0 gives text mode with character addressing, 1 graphics mode
// - host writes index field, then data field accesses the indexed register
// - indices 09h to 0Fh ignore writes and read as zero
// - four fill value bits give all-ones or all-zeros bytes per plane
package vpgd_pkg;
  localparam logic [3:0] IDX_FILL_VALUE = 4'h0;
  localparam logic [3:0] IDX_FILL_ENABLE = 4'h1;
  localparam logic [3:0] IDX_COMPARE_REF = 4'h2;
  localparam logic [3:0] IDX_ROTATE_LOGIC = 4'h3;
  localparam logic [3:0] IDX_READ_PLANE = 4'h4;
  localparam logic [3:0] IDX_RW_PATH = 4'h5;
  localparam logic [3:0] IDX_ADDR_OPTIONS = 4'h6;
  localparam logic [3:0] IDX_COMPARE_EN = 4'h7;
  localparam logic [3:0] IDX_BIT_WRITE_EN = 4'h8;
  localparam int NUM_REGS = 9;
  // implemented bits per register; reserved bits stay zero
  localparam logic [7:0] MASK_FILL_VALUE = 8'h0F;
  localparam logic [7:0] MASK_FILL_ENABLE = 8'h0F;
  localparam logic [7:0] MASK_COMPARE_REF = 8'h0F;
  localparam logic [7:0] MASK_ROTATE_LOGIC = 8'h1F;
  localparam logic [7:0] MASK_READ_PLANE = 8'h03;
  localparam logic [7:0] MASK_RW_PATH = 8'h7B;
  localparam logic [7:0] MASK_ADDR_OPTIONS = 8'h0F;
  localparam logic [7:0] MASK_COMPARE_EN = 8'h0F;
  localparam logic [7:0] MASK_BIT_WRITE_EN = 8'hFF;
  localparam logic [7:0] REG_RESET = 8'h00;
  // field positions
  localparam int ROT_LSB = 0;
  localparam int LOGIC_OP_LSB = 3;
  localparam int WR_PATH_LSB = 0;
  localparam int RD_PATH_BIT = 3;
  localparam int ODD_EVEN_BIT = 4;
  localparam int SHIFT_INTERLEAVE_BIT = 5;
  localparam int PACKED_COLOUR_BIT = 6;
  localparam int GRAPHICS_BIT = 0;
  localparam int CHAIN_ODD_BIT = 1;
  localparam int MEM_MAP_LSB = 2;
  localparam logic [1:0] WR_PATH_FILL = 2'h0;
  localparam logic [1:0] WR_PATH_LATCH = 2'h1;
  localparam logic [1:0] WR_PATH_REPLICATE = 2'h2;
  localparam logic [1:0] WR_PATH_EXPAND = 2'h3;
  localparam logic [1:0] OP_PASS = 2'h0;
  localparam logic [1:0] OP_AND = 2'h1;
  localparam logic [1:0] OP_OR = 2'h2;
  localparam logic [1:0] OP_XOR = 2'h3;
  typedef logic [3:0][7:0] vpgd_planes_t;
  typedef struct packed {
    logic graphics;
    logic chain_odd_even;
    logic [1:0] mem_map_sel;
    logic packed_colour_load;
    logic shift_interleave;
  } vpgd_mode_t;
endpackage

//--- rtl/vpgd_datapath.sv
`timescale 1ns/100ps
module vpgd_datapath
  import vpgd_pkg::*;
(
  input wire logic REF_CLK_I, // 200 MHz memory clock
  input wire logic RST_N_I, // synchronous reset, active low
  input wire logic REG_IDX_WE_I, // write controller index field
  input wire logic REG_DATA_WE_I, // write controller data field
  input wire logic REG_DATA_RE_I, // read controller data field
  input wire logic [7:0] REG_WDATA_I, // index or data byte
  output logic [7:0] REG_RDATA_O, // data field read value
  output logic [3:0] REG_IDX_O, // current controller index
  input wire logic MEM_WR_I, // host write to video memory
  input wire logic MEM_RD_I, // host read from video memory
  input wire logic [1:0] MEM_A_I, // host address bits 1:0
  input wire logic [7:0] MEM_WDATA_I, // host write byte
  input wire vpgd_planes_t PLANE_RDATA_I, // four plane bytes, valid with MEM_RD_I
  input wire logic FOUR_PLANE_CHAIN_I, // chain-four from sequencer
  output vpgd_planes_t PLANE_WDATA_O, // four plane bytes to store
  output logic PLANE_WE_O, // one-cycle write strobe
  output logic [7:0] MEM_RDATA_O, // host read byte
  output logic MEM_RVALID_O, // one-cycle read answer strobe
  output vpgd_mode_t MODE_O // mode bits for display side
);

  ////////////////////////////////////////////////////////////////////////////
  // controller registers

  logic [3:0] idx_ff, nxt_idx;
  logic [7:0] regs_ff [NUM_REGS];
  logic [7:0] nxt_regs [NUM_REGS];
  logic [7:0] reg_rdata_ff, nxt_reg_rdata;
  logic [7:0] reg_mask [NUM_REGS];

  assign reg_mask[0] = MASK_FILL_VALUE;
  assign reg_mask[1] = MASK_FILL_ENABLE;
  assign reg_mask[2] = MASK_COMPARE_REF;
  assign reg_mask[3] = MASK_ROTATE_LOGIC;
  assign reg_mask[4] = MASK_READ_PLANE;
  assign reg_mask[5] = MASK_RW_PATH;
  assign reg_mask[6] = MASK_ADDR_OPTIONS;
  assign reg_mask[7] = MASK_COMPARE_EN;
  assign reg_mask[8] = MASK_BIT_WRITE_EN;

  wire idx_mapped = (idx_ff <= IDX_BIT_WRITE_EN);

  always_comb begin
    nxt_idx = idx_ff;
    nxt_reg_rdata = reg_rdata_ff;
    for (int i = 0; i < NUM_REGS; i++) begin
      nxt_regs[i] = regs_ff[i];
    end
    if (REG_IDX_WE_I) begin
      nxt_idx = REG_WDATA_I[3:0];
    end
    if (REG_DATA_WE_I && idx_mapped) begin
      nxt_regs[idx_ff] = REG_WDATA_I & reg_mask[idx_ff];
    end
    if (REG_DATA_RE_I) begin
      nxt_reg_rdata = idx_mapped ? regs_ff[idx_ff] : 8'h00;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      idx_ff <= 4'h0;
      reg_rdata_ff <= 8'h00;
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_ff[i] <= REG_RESET;
      end
    end else begin
      idx_ff <= nxt_idx;
      reg_rdata_ff <= nxt_reg_rdata;
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_ff[i] <= nxt_regs[i];
      end
    end
  end

  assign REG_RDATA_O = reg_rdata_ff;
  assign REG_IDX_O = idx_ff;

  ////////////////////////////////////////////////////////////////////////////
  // field decode

  wire [3:0] fill_value = regs_ff[IDX_FILL_VALUE][3:0];
  wire [3:0] fill_enable = regs_ff[IDX_FILL_ENABLE][3:0];
  wire [3:0] compare_ref = regs_ff[IDX_COMPARE_REF][3:0];
  wire [2:0] rot_amt = regs_ff[IDX_ROTATE_LOGIC][ROT_LSB +: 3];
  wire [1:0] logic_op = regs_ff[IDX_ROTATE_LOGIC][LOGIC_OP_LSB +: 2];
  wire [1:0] read_plane = regs_ff[IDX_READ_PLANE][1:0];
  wire [1:0] wr_path = regs_ff[IDX_RW_PATH][WR_PATH_LSB +: 2];
  wire rd_compare = regs_ff[IDX_RW_PATH][RD_PATH_BIT];
  wire odd_even = regs_ff[IDX_RW_PATH][ODD_EVEN_BIT];
  wire [3:0] compare_en = regs_ff[IDX_COMPARE_EN][3:0];
  wire [7:0] bit_we = regs_ff[IDX_BIT_WRITE_EN];

  vpgd_mode_t nxt_mode, mode_ff;

  always_comb begin
    nxt_mode.graphics = regs_ff[IDX_ADDR_OPTIONS][GRAPHICS_BIT];
    nxt_mode.chain_odd_even = regs_ff[IDX_ADDR_OPTIONS][CHAIN_ODD_BIT];
    nxt_mode.mem_map_sel = regs_ff[IDX_ADDR_OPTIONS][MEM_MAP_LSB +: 2];
    nxt_mode.packed_colour_load = regs_ff[IDX_RW_PATH][PACKED_COLOUR_BIT];
    // packed loading overrides the interleave choice
    nxt_mode.shift_interleave = regs_ff[IDX_RW_PATH][SHIFT_INTERLEAVE_BIT] &
                                ~regs_ff[IDX_RW_PATH][PACKED_COLOUR_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // write datapath

  vpgd_planes_t latch_ff, nxt_latch;
  vpgd_planes_t pwdata_ff;
  // a net, so each plane slice may have its own driver
  wire vpgd_planes_t nxt_pwdata;
  logic pwe_ff;
  logic [7:0] rot_data;
  logic [7:0] wr_mask;

  // circular right rotation by rot_amt
  always_comb begin
    rot_data = 8'(({MEM_WDATA_I, MEM_WDATA_I} >> rot_amt));
    wr_mask = (wr_path == WR_PATH_EXPAND) ? (rot_data & bit_we) : bit_we;
  end

  generate
    for (genvar p = 0; p < 4; p++) begin : g_plane
      logic [7:0] src;
      logic [7:0] blu;
      logic [7:0] pw;
      always_comb begin
        case (wr_path)
          WR_PATH_FILL: src = fill_enable[p] ? {8{fill_value[p]}} : rot_data;
          WR_PATH_REPLICATE: src = {8{MEM_WDATA_I[p]}};
          WR_PATH_EXPAND: src = {8{fill_value[p]}};
          default: src = rot_data;
        endcase
        case (logic_op)
          OP_PASS: blu = src;
          OP_AND: blu = src & latch_ff[p];
          OP_OR: blu = src | latch_ff[p];
          default: blu = src ^ latch_ff[p];
        endcase
        if (wr_path == WR_PATH_LATCH) begin
          pw = latch_ff[p];
        end else begin
          pw = (blu & wr_mask) | (latch_ff[p] & ~wr_mask);
        end
      end
      assign nxt_pwdata[p] = pw;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read datapath

  logic [7:0] cmp_result;
  logic [1:0] rd_sel;
  logic [7:0] nxt_rdata, rdata_ff;
  logic rvalid_ff;

  generate
    for (genvar b = 0; b < 8; b++) begin : g_cmp
      logic [3:0] match;
      for (genvar q = 0; q < 4; q++) begin : g_cq
        // disabled planes count as matching
        assign match[q] = ~compare_en[q] | (PLANE_RDATA_I[q][b] == compare_ref[q]);
      end
      assign cmp_result[b] = &match;
    end
  endgenerate

  always_comb begin
    if (FOUR_PLANE_CHAIN_I) begin
      rd_sel = MEM_A_I;
    end else if (odd_even) begin
      rd_sel = {read_plane[1], MEM_A_I[0]};
    end else begin
      rd_sel = read_plane;
    end
    nxt_rdata = rd_compare ? cmp_result : PLANE_RDATA_I[rd_sel];
    nxt_latch = MEM_RD_I ? PLANE_RDATA_I : latch_ff;
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      latch_ff <= '0;
      pwdata_ff <= '0;
      pwe_ff <= 1'b0;
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
      mode_ff <= '0;
    end else begin
      latch_ff <= nxt_latch;
      // hold last written bytes so the store bus stays quiet between writes
      pwdata_ff <= MEM_WR_I ? nxt_pwdata : pwdata_ff;
      pwe_ff <= MEM_WR_I;
      rdata_ff <= MEM_RD_I ? nxt_rdata : rdata_ff;
      rvalid_ff <= MEM_RD_I;
      mode_ff <= nxt_mode;
    end
  end

  assign PLANE_WDATA_O = pwdata_ff;
  assign PLANE_WE_O = pwe_ff;
  assign MEM_RDATA_O = rdata_ff;
  assign MEM_RVALID_O = rvalid_ff;
  assign MODE_O = mode_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);

  a_reserved_idx_zero: assert property (
    REG_DATA_RE_I && !idx_mapped |=> REG_RDATA_O == 8'h00)
    else $error("reserved index read not zero");
  a_idx_data_read: assert property (
    REG_DATA_RE_I && idx_mapped && !REG_DATA_WE_I |=> REG_RDATA_O == $past(regs_ff[idx_ff]))
    else $error("data read does not match indexed register");
  a_reserved_write_ignored: assert property (
    REG_DATA_WE_I && !idx_mapped && !REG_IDX_WE_I |=> $stable(regs_ff[IDX_BIT_WRITE_EN]))
    else $error("write to reserved index changed a register");
  a_latch_load: assert property (
    MEM_RD_I |=> latch_ff == $past(PLANE_RDATA_I))
    else $error("latches not loaded on read");
  a_latch_path: assert property (
    MEM_WR_I && wr_path == WR_PATH_LATCH && !MEM_RD_I |=> PLANE_WE_O && PLANE_WDATA_O == latch_ff)
    else $error("latch write path wrong");
  a_fill_plane0: assert property (
    MEM_WR_I && wr_path == WR_PATH_FILL && fill_enable[0] && logic_op == OP_PASS && bit_we == 8'hFF
    |=> PLANE_WDATA_O[0] == {8{$past(fill_value[0])}})
    else $error("fill value not written to enabled plane");
  a_mask_keeps_latch: assert property (
    MEM_WR_I && wr_path != WR_PATH_LATCH && bit_we == 8'h00 && !MEM_RD_I
    |=> PLANE_WDATA_O == latch_ff)
    else $error("masked bits not preserved");
  a_compare_all_off: assert property (
    MEM_RD_I && rd_compare && compare_en == 4'h0 |=> MEM_RDATA_O == 8'hFF && MEM_RVALID_O)
    else $error("disabled compare not all ones");
  a_plane_read_sel: assert property (
    MEM_RD_I && !rd_compare && !FOUR_PLANE_CHAIN_I && !odd_even
    |=> MEM_RDATA_O == $past(PLANE_RDATA_I[read_plane]))
    else $error("plane read select wrong");
  a_chain_read: assert property (
    MEM_RD_I && !rd_compare && FOUR_PLANE_CHAIN_I |=> MEM_RDATA_O == $past(PLANE_RDATA_I[MEM_A_I]))
    else $error("chained read select wrong");
  a_replicate_pass: assert property (
    MEM_WR_I && wr_path == WR_PATH_REPLICATE && logic_op == OP_PASS && bit_we == 8'hFF
    |=> PLANE_WDATA_O[2] == {8{$past(MEM_WDATA_I[2])}})
    else $error("replicate path wrong");

  c_compare_read: cover property (MEM_RD_I && rd_compare ##1 MEM_RVALID_O);
  c_expand_write: cover property (MEM_WR_I && wr_path == WR_PATH_EXPAND ##1 PLANE_WE_O);
  c_read_then_write: cover property (MEM_RD_I ##1 MEM_WR_I && logic_op == OP_XOR);
  c_odd_even_read: cover property (MEM_RD_I && odd_even && MEM_A_I[0]);

endmodule

//--- dv/vpgd_plane_model.sv
`timescale 1ns/100ps
module vpgd_plane_model
  import vpgd_pkg::*;
(
  input wire logic clk_i, // memory clock
  input wire logic rst_n_i, // clears the store for a known start
  input wire logic we_i, // store strobe
  input wire vpgd_planes_t wdata_i, // bytes to store
  input wire logic rd_i, // host read cycle
  output vpgd_planes_t rdata_o // four plane bytes
);
  vpgd_planes_t store_ff;
  vpgd_planes_t nxt_store;

  always_comb begin
    nxt_store = we_i ? wdata_i : store_ff;
  end

  always_ff @(posedge clk_i) begin
    store_ff <= rst_n_i ? nxt_store : '0;
  end

  // outside read cycles the bus shows inverted data so stale bytes cannot pass
  assign rdata_o = rd_i ? store_ff : ~store_ff;
endmodule

//--- dv/tb.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s expected %0h seen %0h", n, e, g); end end
module tb;
  import vpgd_pkg::*;
  logic clk = 0, rst_n = 0, iwe = 0, dwe = 0, dre = 0, mwe = 0, mre = 0, chain = 0;
  logic [7:0] wd = 0, md = 0, rdat, mrdat, q;
  logic [1:0] ma = 0;
  logic [3:0] idx;
  logic pwe, rv;
  vpgd_planes_t prd, pwd;
  vpgd_mode_t mode;
  int failures = 0, n_tests = 0;
  logic [31:0] mem_e = 0, lat = 0;

  always #2.5 clk = ~clk;

  vpgd_datapath dut (.REF_CLK_I(clk), .RST_N_I(rst_n), .REG_IDX_WE_I(iwe), .REG_DATA_WE_I(dwe),
    .REG_DATA_RE_I(dre), .REG_WDATA_I(wd), .REG_RDATA_O(rdat), .REG_IDX_O(idx), .MEM_WR_I(mwe),
    .MEM_RD_I(mre), .MEM_A_I(ma), .MEM_WDATA_I(md), .PLANE_RDATA_I(prd), .FOUR_PLANE_CHAIN_I(chain),
    .PLANE_WDATA_O(pwd), .PLANE_WE_O(pwe), .MEM_RDATA_O(mrdat), .MEM_RVALID_O(rv), .MODE_O(mode));
  vpgd_plane_model mem (.clk_i(clk), .rst_n_i(rst_n), .we_i(pwe), .wdata_i(pwd), .rd_i(mre), .rdata_o(prd));

  ////////////////////////////////////////////////////////////////
  task automatic rw(input logic [3:0] i, input logic [7:0] d);
    @(negedge clk) iwe = 1;
    wd = {4'h0, i};
    @(negedge clk) iwe = 0;
    dwe = 1;
    wd = d;
    @(negedge clk) dwe = 0;
  endtask

  task automatic rr(input logic [3:0] i);
    @(negedge clk) iwe = 1;
    wd = {4'h0, i};
    @(negedge clk) iwe = 0;
    dre = 1;
    @(negedge clk) dre = 0;
    q = rdat;
    `CHK("index", i, idx)
  endtask

  task automatic mwr(input logic [7:0] d, input logic [31:0] e);
    @(negedge clk) mwe = 1;
    md = d;
    @(negedge clk) mwe = 0;
    `CHK("plane_we", 1'b1, pwe)
    `CHK("plane_wdata", e, pwd)
    @(negedge clk) `CHK("we_pulse", 1'b0, pwe)
    mem_e = e;
  endtask

  task automatic mrd(input logic [1:0] a, input logic [7:0] e);
    @(negedge clk) mre = 1;
    ma = a;
    @(negedge clk) mre = 0;
    `CHK("rvalid", 1'b1, rv)
    `CHK("rdata", e, mrdat)
    lat = mem_e;
  endtask

  // reference write path, latches taken from the last read
  function automatic logic [31:0] exp_wr(input logic [1:0] m, input logic [1:0] op, input logic [7:0] h,
    input logic [2:0] r, input logic [3:0] fv, input logic [3:0] fe, input logic [7:0] bm);
    logic [7:0] rh, s, l, mk, v;
    logic [31:0] o;
    rh = 8'({h, h} >> r);
    mk = (m == 2'd3) ? (rh & bm) : bm;
    for (int p = 0; p < 4; p++) begin
      l = lat[p*8 +: 8];
      s = (m == 2'd2) ? {8{h[p]}} : (m == 2'd3 || fe[p]) ? {8{fv[p]}} : rh;
      v = (op == 2'd1) ? (s & l) : (op == 2'd2) ? (s | l) : (op == 2'd3) ? (s ^ l) : s;
      o[p*8 +: 8] = (m == 2'd1) ? l : ((v & mk) | (l & ~mk));
    end
    return o;
  endfunction

  function automatic logic [7:0] colcmp(input logic [3:0] rf, input logic [3:0] en);
    for (int b = 0; b < 8; b++) colcmp[b] = &(~({mem_e[24+b], mem_e[16+b], mem_e[8+b], mem_e[b]} ^ rf) | ~en);
  endfunction

  ////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] msk [9] = '{MASK_FILL_VALUE, MASK_FILL_ENABLE, MASK_COMPARE_REF, MASK_ROTATE_LOGIC,
      MASK_READ_PLANE, MASK_RW_PATH, MASK_ADDR_OPTIONS, MASK_COMPARE_EN, MASK_BIT_WRITE_EN};
    for (int i = 0; i < 16; i++) begin
      rr(4'(i));
      `CHK("reset_val", 8'h00, q)
      rw(4'(i), 8'hFF);
      rr(4'(i));
      `CHK("reg_rw", (i < 9) ? msk[i] : 8'h00, q)
      rw(4'(i), 8'h00);
    end
    $display("test regs done");
  endtask

  task automatic t_write();
    rw(4'h8, 8'hFF);
    rw(4'h1, 8'h0F);
    rw(4'h0, 8'h05);
    mwr(8'h00, 32'h00FF_00FF);
    mrd(2'd0, 8'hFF);
    rw(4'h8, 8'h00);
    mwr(8'h96, lat);
    rw(4'h5, 8'h02);
    rw(4'h8, 8'hFF);
    mwr(8'h96, 32'h00FF_FF00);
    rw(4'h0, 8'h0A);
    rw(4'h1, 8'h06);
    rw(4'h8, 8'hA5);
    for (int m = 0; m < 4; m++) begin
      rw(4'h5, 8'(m));
      for (int op = 0; op < 4; op++) begin
        rw(4'h3, {3'h0, 2'(op), 3'd3});
        mwr(8'h96, exp_wr(2'(m), 2'(op), 8'h96, 3'd3, 4'hA, 4'h6, 8'hA5));
      end
    end
    $display("test write done");
  endtask

  task automatic t_read();
    rw(4'h5, 8'h00);
    for (int p = 0; p < 4; p++) begin
      rw(4'h4, 8'(p));
      mrd(2'd0, mem_e[p*8 +: 8]);
    end
    rw(4'h5, 8'h01);
    mwr(8'h00, lat);
    rw(4'h5, 8'h08);
    rw(4'h4, 8'h03);
    for (int k = 0; k < 5; k++) begin
      rw(4'h2, 8'(k * 5));
      rw(4'h7, 8'(4'hF >> k));
      mrd(2'd0, colcmp(4'(k * 5), 4'(4'hF >> k)));
    end
    $display("test read done");
  endtask

  task automatic t_addr();
    rw(4'h5, 8'h10);
    rw(4'h4, 8'h02);
    mrd(2'd0, mem_e[23:16]);
    mrd(2'd1, mem_e[31:24]);
    rw(4'h5, 8'h00);
    chain = 1;
    mrd(2'd3, mem_e[31:24]);
    chain = 0;
    $display("test addressing done");
  endtask

  task automatic t_mode();
    rw(4'h6, 8'h0F);
    rw(4'h5, 8'h20);
    @(negedge clk) `CHK("mode", 6'h3D, mode)
    rw(4'h5, 8'h60);
    rw(4'h6, 8'h00);
    @(negedge clk) `CHK("mode", 6'h02, mode)
    $display("test mode done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1;
    t_regs();
    t_write();
    t_read();
    t_addr();
    t_mode();
    tally_and_finish();
  end

  // whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
endmodule
